// >>> sim/rcm_mute_ctrl_tb_top.sv
// Self-checking bench for the rate converter mute control block.
// Assumes rcm_pkg is compiled first; bench acts as APB master and as
// the converters' lock and sample tick source.
`timescale 1ns/10ps
`define RCM_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module rcm_mute_ctrl_tb_top;
  import rcm_pkg::*;
  localparam int RS = 4;
  localparam int GW = $clog2(RS + 1);
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [RCM_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [RCM_NCONV-1:0]  lock_in;
  logic                  sample_tick;
  logic [RCM_NCONV-1:0][GW-1:0] conv_gain;
  logic [RCM_NCONV-1:0]  conv_muted;
  logic                  irq;
  int                    n_fail;
  int                    n_checks;
  logic [31:0]           rdat;
  logic                  rerr;
  logic [15:0]           im;
  logic [15:0]           ir;
  int                    b;

  rcm_mute_ctrl #(.RAMP_STEPS(RS)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_in(lock_in), .sample_tick(sample_tick),
    .conv_gain(conv_gain), .conv_muted(conv_muted), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus, stimulus and check tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0000_0000, 4'h0);
    `RCM_CHK("prdata", e, rdat)
    `RCM_CHK("pslverr", 1'b0, rerr)
  endtask : rd_chk

  // One tick every other cycle, outputs checked after the last edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      sample_tick <= 1'b1;
      @(posedge pclk);
      sample_tick <= 1'b0;
    end
    @(posedge pclk);
    #1;
  endtask : tick

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : idle

  task automatic chk_gain(input int c, input logic [GW-1:0] e);
    `RCM_CHK("conv_gain", e, conv_gain[c])
    `RCM_CHK("conv_muted", (e == '0), conv_muted[c])
  endtask : chk_gain

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Whole sequence needs about 250 cycles; generous margin
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0; n_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = '0; lock_in = '0;
    sample_tick = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    `RCM_CHK("conv_muted", 8'hff, conv_muted)
    `RCM_CHK("irq", 1'b0, irq)
    `RCM_CHK("pready", 1'b1, pready)
    rd_chk(RCM_IDX_LOW_LOCK_MUTE, 32'h0);
    rd_chk(RCM_IDX_LOW_RAMP_DIS, 32'h0);
    rd_chk(RCM_IDX_HIGH_LOCK_MUTE, 32'h0);
    rd_chk(RCM_IDX_HIGH_RAMP_DIS, 32'h0);
    rd_chk(RCM_IDX_IRQ_STATUS, 32'h0);
    rd_chk(RCM_IDX_IRQ_MASK, 32'h0);
    xfer(1'b0, 16'h0000, 32'h0, 4'h0);
    `RCM_CHK("unmapped err", 1'b1, rerr)
    `RCM_CHK("unmapped data", 32'h0, rdat)
    // Lock all converters, ramp up to full gain
    @(posedge pclk);
    lock_in <= 8'hff;
    idle(6);
    for (int c = 0; c < 8; c++) chk_gain(c, 3'h0);
    tick(RS);
    for (int c = 0; c < 8; c++) chk_gain(c, 3'h4);
    rd_chk(RCM_IDX_LOW_LOCK_MUTE, 32'h0f00);
    rd_chk(RCM_IDX_IRQ_STATUS, 32'hff00);
    `RCM_CHK("irq masked", 1'b0, irq)
    wr(RCM_IDX_IRQ_MASK, 32'h0000_ff00);
    `RCM_CHK("irq set", 1'b1, irq)
    wr(RCM_IDX_IRQ_STATUS, 32'h0000_ff00);
    `RCM_CHK("irq clr", 1'b0, irq)
    // Lane 0 off leaves the mute bits alone
    xfer(1'b1, RCM_IDX_LOW_LOCK_MUTE, 32'h0000_000f, 4'he);
    rd_chk(RCM_IDX_LOW_LOCK_MUTE, 32'h0f00);
    for (int g = 0; g < 2; g++) begin
      im = g ? RCM_IDX_HIGH_LOCK_MUTE : RCM_IDX_LOW_LOCK_MUTE;
      ir = g ? RCM_IDX_HIGH_RAMP_DIS : RCM_IDX_LOW_RAMP_DIS;
      b = 4 * g;
      wr(im, 32'h0000_0002);
      tick(1);
      chk_gain(b + 1, 3'h3);
      chk_gain(b, 3'h4);
      tick(3);
      chk_gain(b + 1, 3'h0);
      wr(im, 32'h0000_0000);
      tick(RS);
      chk_gain(b + 1, 3'h4);
      wr(ir, 32'h0000_0001);
      wr(im, 32'h0000_000f);
      tick(2);
      for (int c = 0; c < 4; c++) chk_gain(b + c, 3'h4);
      @(posedge pclk);
      lock_in[b + 2] <= 1'b0;
      idle(6);
      chk_gain(b + 2, 3'h0);
      chk_gain(b + 3, 3'h4);
      rd_chk(im, 32'h0000_0b0f);
      @(posedge pclk);
      lock_in[b + 2] <= 1'b1;
      idle(6);
      chk_gain(b + 2, 3'h4);
      wr(im, 32'h0000_0000);
      wr(ir, 32'hffff_ffff);
      rd_chk(ir, 32'h0000_0001);
      wr(ir, 32'h0000_0000);
      wr(im, 32'hffff_ffff);
      rd_chk(im, 32'h0000_0f0f);
      wr(im, 32'h0000_0000);
      tick(RS);
    end
    rd_chk(RCM_IDX_IRQ_STATUS, 32'h0000_4444);
    `RCM_CHK("irq rise", 1'b1, irq)
    wr(RCM_IDX_IRQ_STATUS, 32'h0000_ffff);
    `RCM_CHK("irq end", 1'b0, irq)
    print_verdict();
  end
endmodule : rcm_mute_ctrl_tb_top

// >>> src/rcm_mute_ctrl.sv
// Mute, lock status and mute ramp control for eight stereo rate
// converters in two groups of four, with an APB register slave.
// Assumes sample_tick is a one-cycle strobe on pclk, one per sample
// period; lock_in comes from converter logic of another clock.
//
// Summary of operation
// - With the low group ramp disable bit at zero, converters 0-3 mute by ramping gain down.
// - With the low group ramp disable bit at one, converters 0-3 mute at once.
// - With the low group ramp disable bit at one, low mute bits are ignored and only lock loss mutes.
// - With the high group ramp disable bit at zero, converters 4-7 mute by ramping gain down.
// - With the high group ramp disable bit at one, converters 4-7 mute at once.
// - With the high group ramp disable bit at one, high mute bits are ignored and only lock loss mutes.
// - A converter out of lock shows zero in its read-only lock flag (bits 11:8) and is muted.
// - Mute bits 3:0 are active high: one mutes, zero unmutes the converter.
// - In the high group mute bit 0 drives converter 4 and bits 1-3 drive converters 5-7; all reset to zero.
// - A manual mute also ramps, unless the group ramp disable bit overrides it.
// - In the low group mute bit 0 and lock bit 8 belong to converter 0, later bits in order to converter 3.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module rcm_mute_ctrl #(
  parameter int unsigned  RAMP_STEPS = rcm_pkg::RCM_RAMP_STEPS,
  localparam int unsigned CW         = $clog2(RAMP_STEPS + 1)
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [rcm_pkg::RCM_ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [rcm_pkg::RCM_NCONV-1:0]       lock_in,
  input  wire logic                                sample_tick,
  output logic      [rcm_pkg::RCM_NCONV-1:0][CW-1:0] conv_gain,
  output logic      [rcm_pkg::RCM_NCONV-1:0]       conv_muted,
  output logic                                     irq
);
  import rcm_pkg::*;

  localparam logic [CW-1:0] GMAX = CW'(RAMP_STEPS);

  generate
    if (RAMP_STEPS < 1 || RAMP_STEPS > 4095) begin : g_bad_steps
      $error("RAMP_STEPS must lie between 1 and 4095");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lock synchroniser
  // ----------------------------------------------------------------
  logic [RCM_NCONV-1:0] lock_meta;
  logic [RCM_NCONV-1:0] lock_s;
  logic [RCM_NCONV-1:0] lock_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta <= '0;
      lock_s    <= '0;
      lock_prev <= '0;
    end else begin
      lock_meta <= lock_in;
      lock_s    <= lock_meta;
      lock_prev <= lock_s;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_en;
  logic        word_ok;
  logic [15:0] idx;
  logic        hit_llm;
  logic        hit_lrd;
  logic        hit_hlm;
  logic        hit_hrd;
  logic        hit_ist;
  logic        hit_imk;
  logic        mapped;

  assign pready  = 1'b1;
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign idx     = paddr[17:2];
  assign word_ok = (paddr[1:0] == 2'b00)
                 && (paddr[RCM_ADDR_W-1:18] == '0);
  assign hit_llm = word_ok && (idx == RCM_IDX_LOW_LOCK_MUTE);
  assign hit_lrd = word_ok && (idx == RCM_IDX_LOW_RAMP_DIS);
  assign hit_hlm = word_ok && (idx == RCM_IDX_HIGH_LOCK_MUTE);
  assign hit_hrd = word_ok && (idx == RCM_IDX_HIGH_RAMP_DIS);
  assign hit_ist = word_ok && (idx == RCM_IDX_IRQ_STATUS);
  assign hit_imk = word_ok && (idx == RCM_IDX_IRQ_MASK);
  assign mapped  = hit_llm | hit_lrd | hit_hlm | hit_hrd
                 | hit_ist | hit_imk;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0]  mute_low,   next_mute_low;
  logic [3:0]  mute_high,  next_mute_high;
  logic        rdis_low,   next_rdis_low;
  logic        rdis_high,  next_rdis_high;
  logic [15:0] irq_status, next_irq_status;
  logic [15:0] irq_mask,   next_irq_mask;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] rd_val;
  logic [15:0] w1c;

  always_comb begin
    rd_val = '0;
    if (hit_llm) begin
      rd_val[RCM_LOCK_LSB +: 4] = lock_s[3:0];
      rd_val[RCM_MUTE_LSB +: 4] = mute_low;
    end
    if (hit_hlm) begin
      rd_val[RCM_LOCK_LSB +: 4] = lock_s[7:4];
      rd_val[RCM_MUTE_LSB +: 4] = mute_high;
    end
    if (hit_lrd) rd_val[RCM_RDIS_BIT] = rdis_low;
    if (hit_hrd) rd_val[RCM_RDIS_BIT] = rdis_high;
    if (hit_ist) rd_val[15:0] = irq_status;
    if (hit_imk) rd_val[15:0] = irq_mask;
  end

  always_comb begin
    next_mute_low  = mute_low;
    next_mute_high = mute_high;
    next_rdis_low  = rdis_low;
    next_rdis_high = rdis_high;
    next_irq_mask  = irq_mask;
    w1c            = '0;
    // Only writable bits are stored; the rest of each word is dropped
    if (wr_en && pstrb[0]) begin
      if (hit_llm) next_mute_low  = pwdata[RCM_MUTE_LSB +: 4];
      if (hit_hlm) next_mute_high = pwdata[RCM_MUTE_LSB +: 4];
      if (hit_lrd) next_rdis_low  = pwdata[RCM_RDIS_BIT];
      if (hit_hrd) next_rdis_high = pwdata[RCM_RDIS_BIT];
      if (hit_imk) next_irq_mask[7:0] = pwdata[7:0];
      if (hit_ist) w1c[7:0] = pwdata[7:0];
    end
    if (wr_en && pstrb[1]) begin
      if (hit_imk) next_irq_mask[15:8] = pwdata[15:8];
      if (hit_ist) w1c[15:8] = pwdata[15:8];
    end
    // New lock events win over a clear in the same cycle
    next_irq_status = (irq_status & ~w1c)
                    | {lock_s & ~lock_prev, lock_prev & ~lock_s};
    // Read data is captured in the setup phase, so no wait state
    next_prdata  = setup ? rd_val : prdata;
    next_pslverr = setup ? ~mapped : pslverr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_low   <= RCM_MUTE_RST;
      mute_high  <= RCM_MUTE_RST;
      rdis_low   <= RCM_RDIS_RST;
      rdis_high  <= RCM_RDIS_RST;
      irq_status <= RCM_IRQ_RST;
      irq_mask   <= RCM_IRQ_RST;
      prdata     <= RCM_DATA_RST;
      pslverr    <= 1'b0;
    end else begin
      mute_low   <= next_mute_low;
      mute_high  <= next_mute_high;
      rdis_low   <= next_rdis_low;
      rdis_high  <= next_rdis_high;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Mute targets and gain ramps
  // ----------------------------------------------------------------
  logic [RCM_NCONV-1:0]         target;
  logic [RCM_NCONV-1:0]         abrupt;
  logic [RCM_NCONV-1:0]         mute_all;
  logic [RCM_NCONV-1:0][CW-1:0] next_gain;

  assign mute_all = {mute_high, mute_low};

  always_comb begin
    for (int i = 0; i < RCM_NCONV; i++) begin
      abrupt[i] = (i < RCM_GROUP) ? rdis_low : rdis_high;
      // Lock loss always mutes; manual bits only while ramping
      target[i] = ~lock_s[i] | (mute_all[i] & ~abrupt[i]);
      next_gain[i] = conv_gain[i];
      if (target[i] && abrupt[i]) begin
        next_gain[i] = '0;
      end else if (target[i]) begin
        if (sample_tick && conv_gain[i] != '0)
          next_gain[i] = conv_gain[i] - CW'(1);
      end else if (abrupt[i]) begin
        next_gain[i] = GMAX;
      end else if (sample_tick && conv_gain[i] != GMAX) begin
        next_gain[i] = conv_gain[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_gain  <= '0;
      conv_muted <= '1;
    end else begin
      conv_gain <= next_gain;
      for (int i = 0; i < RCM_NCONV; i++)
        conv_muted[i] <= (next_gain[i] == '0);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ramp_down(int n);
    target[n] && !abrupt[n] && sample_tick && conv_gain[n] != '0;
  endsequence

  sequence s_llm_write;
    psel && penable && pwrite && pstrb[0] && hit_llm;
  endsequence

  property p_low_ramp;
    @(posedge pclk) disable iff (!presetn)
    s_ramp_down(1) |=> conv_gain[1] == $past(conv_gain[1]) - CW'(1);
  endproperty
  a_low_ramp: assert property (p_low_ramp)
    else $error("low group gain did not step down");

  property p_low_abrupt;
    @(posedge pclk) disable iff (!presetn)
    (rdis_low && target[2]) |=> conv_gain[2] == '0 && conv_muted[2];
  endproperty
  a_low_abrupt: assert property (p_low_abrupt)
    else $error("low group abrupt mute not immediate");

  property p_low_ignore;
    @(posedge pclk) disable iff (!presetn)
    rdis_low |-> target[3:0] == ~lock_s[3:0];
  endproperty
  a_low_ignore: assert property (p_low_ignore)
    else $error("low group mute bits not ignored");

  property p_high_ramp;
    @(posedge pclk) disable iff (!presetn)
    s_ramp_down(5) |=> conv_gain[5] == $past(conv_gain[5]) - CW'(1);
  endproperty
  a_high_ramp: assert property (p_high_ramp)
    else $error("high group gain did not step down");

  property p_high_abrupt;
    @(posedge pclk) disable iff (!presetn)
    (rdis_high && target[6]) |=> conv_gain[6] == '0 && conv_muted[6];
  endproperty
  a_high_abrupt: assert property (p_high_abrupt)
    else $error("high group abrupt mute not immediate");

  property p_high_ignore;
    @(posedge pclk) disable iff (!presetn)
    rdis_high |-> target[7:4] == ~lock_s[7:4];
  endproperty
  a_high_ignore: assert property (p_high_ignore)
    else $error("high group mute bits not ignored");

  property p_lock_mutes;
    @(posedge pclk) disable iff (!presetn)
    (setup && hit_hlm && !lock_s[4])
      |=> prdata[RCM_LOCK_LSB] == 1'b0 && target[4];
  endproperty
  a_lock_mutes: assert property (p_lock_mutes)
    else $error("unlocked converter not flagged or not muted");

  property p_mute_write;
    @(posedge pclk) disable iff (!presetn)
    s_llm_write |=> mute_low == $past(pwdata[3:0]);
  endproperty
  a_mute_write: assert property (p_mute_write)
    else $error("mute bits not taken from write");

  property p_high_map;
    @(posedge pclk) disable iff (!presetn)
    (mute_high[0] && !rdis_high) |-> target[4];
  endproperty
  a_high_map: assert property (p_high_map)
    else $error("high mute bit 0 does not mute converter 4");

  property p_manual_ramp;
    @(posedge pclk) disable iff (!presetn)
    (mute_low[1] && !rdis_low && lock_s[1] && conv_gain[1] == GMAX)
      ##1 sample_tick |=> conv_gain[1] < GMAX && conv_gain[1] != '0
                          || RAMP_STEPS == 1;
  endproperty
  a_manual_ramp: assert property (p_manual_ramp)
    else $error("manual mute did not ramp");

  property p_low_map;
    @(posedge pclk) disable iff (!presetn)
    (setup && hit_llm) |=> prdata[RCM_LOCK_LSB +: 4] == $past(lock_s[3:0])
                       && prdata[3:0] == $past(mute_low);
  endproperty
  a_low_map: assert property (p_low_map)
    else $error("low group bit order wrong");

  property p_ramp_up;
    @(posedge pclk) disable iff (!presetn)
    (!target[2] && !abrupt[2] && sample_tick && conv_gain[2] != GMAX)
      |=> conv_gain[2] == $past(conv_gain[2]) + CW'(1);
  endproperty
  a_ramp_up: assert property (p_ramp_up)
    else $error("unmute did not ramp up");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (setup && (hit_lrd || hit_hrd)) |=> prdata[31:1] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

endmodule : rcm_mute_ctrl

// >>> src/rcm_pkg.sv
// Package for the rate converter mute control block.
// Assumes a single APB clock domain; register indices map to byte
// addresses as four times the index.
package rcm_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned RCM_NCONV       = 8;
  localparam int unsigned RCM_GROUP       = 4;
  localparam int unsigned RCM_ADDR_W      = 20;
  localparam int unsigned RCM_RAMP_STEPS  = 64;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] RCM_IDX_LOW_LOCK_MUTE  = 16'he101;
  localparam logic [15:0] RCM_IDX_LOW_RAMP_DIS   = 16'he103;
  localparam logic [15:0] RCM_IDX_HIGH_LOCK_MUTE = 16'he141;
  localparam logic [15:0] RCM_IDX_HIGH_RAMP_DIS  = 16'he143;
  localparam logic [15:0] RCM_IDX_IRQ_STATUS     = 16'he1f0;
  localparam logic [15:0] RCM_IDX_IRQ_MASK       = 16'he1f1;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned RCM_MUTE_LSB  = 0;
  localparam int unsigned RCM_LOCK_LSB  = 8;
  localparam int unsigned RCM_RDIS_BIT  = 0;
  localparam int unsigned RCM_RISE_LSB  = 8;
  localparam logic [3:0]  RCM_MUTE_RST  = 4'h0;
  localparam logic        RCM_RDIS_RST  = 1'b0;
  localparam logic [15:0] RCM_IRQ_RST   = 16'h0000;
  localparam logic [31:0] RCM_DATA_RST  = 32'h0000_0000;

endpackage : rcm_pkg
